// ---- design/absr_dev.sv ----
// converter end: byte-wide and serial result readout
`timescale 1ns/100ps
`include "absr_regs.svh"

//Contract
// - both selects high select byte readout
// - byte mode: result sent as two bytes
// - order pin high sends upper byte first
// - chip select fall enables low data lines
// - each read fall gives next byte, ascending
// - byte marker high two reads, then low
// - select high, byte-select low: serial readout
// - chip select high: serial outputs float
// - chip select fall drives top bit at once
// - later bits shift on rising serial clock
// - sixteen clocks per channel, ascending order
// - output a 1..8, output b 5..8,1..4
// - serial marker high until 16th falling clock
// - marker high interval marks channel 5 on b
// - single-output host supplies 128 clocks
// - read while busy gives previous results
// - results refresh when busy falls
module absr_dev
  import absr_pkg::*;
#(
  parameter int NCH = `ABSR_NUM_CH     // channel count
) (
  input  wire logic       core_clk_i,  // core clock
  input  wire logic       arst_n_i,    // async reset, active low
  absr_if.dev             lnk,         // pins toward the host
  input  wire logic       busy_i,      // conversion phase, high busy
  input  wire logic [NCH*16-1:0] result_i, // fresh results, ch1 low
  output absr_pkg::absr_mode_e mode_o  // decoded readout mode
);
  import absr_pkg::*;

  localparam int HALF = NCH / 2;

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [6:0] s1_r;
  logic [6:0] s2_r;
  logic [6:0] s3_r;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= 7'h0f;
      s2_r <= 7'h0f;
      s3_r <= 7'h0f;
    end else begin
      s1_r <= {lnk.interface_select, lnk.byte_serial_select,
               lnk.byte_order_select, 1'b1, lnk.cs_n, lnk.rd_n,
               lnk.sclk};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic sel_if, sel_bs, sel_ord, cs_n, rd_n, sck;
  logic cs_fall, rd_fall, sck_rise, sck_fall;
  assign {sel_if, sel_bs, sel_ord} = s2_r[6:4];
  assign cs_n     = s2_r[2];
  assign rd_n     = s2_r[1];
  assign sck      = s2_r[0];
  assign cs_fall  = s3_r[2] && !cs_n;
  assign rd_fall  = s3_r[1] && !rd_n && !cs_n;
  assign sck_rise = !s3_r[0] && sck && !cs_n;
  assign sck_fall = s3_r[0] && !sck && !cs_n;

  absr_mode_e mode;
  always_comb begin
    if (!sel_if) mode = ABSR_MODE_PAR;
    else if (sel_bs) mode = ABSR_MODE_BYTE;
    else mode = ABSR_MODE_SER;
  end

  // ==========================================================
  // result registers
  // ==========================================================
  logic [NCH*16-1:0] res_r;
  logic              busy_q_r;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q_r <= 1'b0;
      res_r    <= '0;
    end else begin
      busy_q_r <= busy_i;
      // only the busy fall loads, so reads during busy see old data
      if (busy_q_r && !busy_i) res_r <= result_i;
    end
  end

  function automatic absr_word_t word_of(input logic [3:0] ch);
    return res_r[ch*16 +: 16];
  endfunction

  function automatic logic bit_of(input logic [3:0] ch,
                                  input logic [3:0] b);
    return res_r[ch*16 + b];
  endfunction

  // ==========================================================
  // byte mode: words pass the buffer, split to bytes
  // ==========================================================
  logic [3:0] fetch_r;   // next channel to fetch
  logic [4:0] rdcnt_r;   // read falls seen this frame
  logic       half_r;    // second byte of head word
  absr_word_t head;
  logic       head_v;
  logic       pop;
  logic       buf_rdy;
  logic       push;
  assign push = (mode == ABSR_MODE_BYTE) && !cs_n && fetch_r < NCH;
  assign pop  = rd_fall && half_r && (mode == ABSR_MODE_BYTE);

  absr_skid #(.W(16)) u_buf (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .in_data_i  (word_of(fetch_r)),
    .in_valid_i (push),
    .in_ready_o (buf_rdy),
    .out_data_o (head),
    .out_valid_o(head_v),
    .out_ready_i(pop)
  );

  // ==========================================================
  // serial shifter
  // ==========================================================
  logic [3:0] sbit_r;  // bit index within word
  logic [3:0] sch_r;   // word index within frame
  logic [6:0] sfall_r; // falling clocks since frame start
  logic       sdone_r;

  function automatic logic [3:0] b_chan(input logic [3:0] k);
    return (k < HALF) ? 4'(k + HALF) : 4'(k - HALF);
  endfunction

  // ==========================================================
  // output flops
  // ==========================================================
  logic [7:0] db_r;
  logic       db_oe_r, sa_r, sb_r, ser_oe_r, mk_r, mk_oe_r;
  absr_mode_e mode_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fetch_r <= 4'h0;
      rdcnt_r <= 5'h0;
      half_r  <= 1'b0;
      db_r    <= 8'h00;
      db_oe_r <= 1'b0;
    end else if (mode != ABSR_MODE_BYTE || cs_n) begin
      fetch_r <= 4'h0;
      rdcnt_r <= 5'h0;
      half_r  <= 1'b0;
      db_oe_r <= 1'b0;
    end else begin
      if (push && buf_rdy) fetch_r <= fetch_r + 4'h1;
      if (cs_fall) db_oe_r <= 1'b1;
      if (rd_fall && head_v) begin
        half_r  <= ~half_r;
        if (rdcnt_r != 5'h1f) rdcnt_r <= rdcnt_r + 5'h1;
        // order pin picks upper or lower byte first
        if (half_r ^ sel_ord) db_r <= head[15:8];
        else db_r <= head[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sbit_r   <= 4'h0;
      sch_r    <= 4'h0;
      sfall_r  <= 7'h0;
      sdone_r  <= 1'b0;
      sa_r     <= 1'b0;
      sb_r     <= 1'b0;
      ser_oe_r <= 1'b0;
    end else if (mode != ABSR_MODE_SER || cs_n) begin
      ser_oe_r <= 1'b0;
      // a word cut after its last bit, before the rise that advances
      // it, still counts as read; a word already advanced by that rise
      // or a finished frame must not advance a second time
      if (sbit_r == 4'hf) begin
        sch_r <= (sch_r >= 4'(NCH - 1)) ? 4'h0 : sch_r + 4'h1;
      end
      sbit_r  <= 4'h0;
      sfall_r <= 7'h0;
      sdone_r <= 1'b0;
    end else if (cs_fall) begin
      ser_oe_r <= 1'b1;
      sa_r <= bit_of(sch_r, 4'hf);
      sb_r <= bit_of(b_chan(sch_r), 4'hf);
    end else if (sck_rise && sfall_r != 7'h0 && !sdone_r) begin
      if (sbit_r == 4'hf) begin
        if (sch_r == NCH - 1) begin
          sdone_r <= 1'b1;
          sch_r   <= 4'h0;
        end else begin
          sch_r <= sch_r + 4'h1;
          sa_r  <= bit_of(sch_r + 4'h1, 4'hf);
          sb_r  <= bit_of(b_chan(sch_r + 4'h1), 4'hf);
        end
        sbit_r <= 4'h0;
      end else begin
        sbit_r <= sbit_r + 4'h1;
        sa_r <= bit_of(sch_r, 4'he - sbit_r);
        sb_r <= bit_of(b_chan(sch_r), 4'he - sbit_r);
      end
    end else if (sck_fall) begin
      if (sfall_r != 7'h7f) sfall_r <= sfall_r + 7'h1;
      if (sbit_r == 4'hf) sbit_r <= 4'hf;
    end
  end

  // rising clock after each word's 16th fall advances; a rise before the
  // frame's first falling clock is ignored since the top bit is already out
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mk_r    <= 1'b0;
      mk_oe_r <= 1'b0;
      mode_r  <= ABSR_MODE_PAR;
    end else begin
      mode_r <= mode;
      if (cs_n || mode == ABSR_MODE_PAR) begin
        mk_oe_r <= 1'b0;
        mk_r    <= 1'b0;
      end else if (mode == ABSR_MODE_BYTE) begin
        if (rd_fall && head_v) begin
          mk_oe_r <= 1'b1;
          mk_r    <= (rdcnt_r < 5'h2);
        end
      end else begin
        if (cs_fall) begin
          mk_oe_r <= 1'b1;
          mk_r    <= (sch_r == 4'h0);
        end else if (sck_fall && sbit_r == 4'hf) begin
          mk_r <= 1'b0;
        end
      end
    end
  end

  assign lnk.low_byte_lines       = db_r;
  assign lnk.low_byte_oe          = db_oe_r;
  assign lnk.serial_out_a         = sa_r;
  assign lnk.serial_out_b         = sb_r;
  assign lnk.serial_oe            = ser_oe_r;
  assign lnk.first_channel_marker = mk_r;
  assign lnk.marker_oe            = mk_oe_r;
  assign mode_o                   = mode_r;
endmodule // absr_dev

// ---- design/absr_regs.svh ----
// timing counts and fixed figures for the byte/serial result readout
`ifndef ABSR_REGS_SVH
`define ABSR_REGS_SVH
`define ABSR_NUM_CH        8
`define ABSR_RES_W         16
`define ABSR_BYTE_W        8
`define ABSR_BYTE_READS    16
`define ABSR_SER_BITS      16
`define ABSR_SER_TOTAL     128
`define ABSR_CLK_NS        5
`define ABSR_HOST_HALF_NS  24
`define ABSR_HOST_HALF_CYC \
  ((`ABSR_HOST_HALF_NS + `ABSR_CLK_NS - 1) / `ABSR_CLK_NS)
`endif

// ---- design/absr_pkg.sv ----
// shared types for the byte/serial result readout
package absr_pkg;
  typedef logic [15:0] absr_word_t;
  typedef logic [7:0]  absr_byte_t;
  typedef enum logic [1:0] {
    ABSR_MODE_PAR,
    ABSR_MODE_BYTE,
    ABSR_MODE_SER
  } absr_mode_e;
endpackage

// ---- design/absr_if.sv ----
// pins between the converter's readout port and its host
`timescale 1ns/100ps
interface absr_if;
  logic       interface_select;   // host drives high for byte/serial
  logic       byte_serial_select; // high byte mode, low serial mode
  logic       byte_order_select;  // byte mode: high sends upper first
  logic       cs_n;               // chip select, active low
  logic       rd_n;               // read strobe, active low
  logic       sclk;               // serial clock from host
  logic [7:0] low_byte_lines;     // device data, byte mode
  logic       low_byte_oe;        // device drives low_byte_lines
  logic       serial_out_a;       // serial data a
  logic       serial_out_b;       // serial data b
  logic       serial_oe;          // device drives serial outputs
  logic       first_channel_marker;
  logic       marker_oe;          // device drives marker
  modport dev (
    input  interface_select, byte_serial_select, byte_order_select,
    input  cs_n, rd_n, sclk,
    output low_byte_lines, low_byte_oe, serial_out_a, serial_out_b,
    output serial_oe, first_channel_marker, marker_oe
  );
  modport host (
    output interface_select, byte_serial_select, byte_order_select,
    output cs_n, rd_n, sclk,
    input  low_byte_lines, low_byte_oe, serial_out_a, serial_out_b,
    input  serial_oe, first_channel_marker, marker_oe
  );
endinterface

// ---- design/absr_skid.sv ----
// two-entry buffer with valid/ready on both sides
`timescale 1ns/100ps
module absr_skid #(
  parameter int W = 16              // word width
) (
  input  wire logic         core_clk_i, // core clock
  input  wire logic         arst_n_i,   // async reset, active low
  input  wire logic [W-1:0] in_data_i,  // word in
  input  wire logic         in_valid_i, // word in valid
  output logic              in_ready_o, // room for a word
  output logic [W-1:0]      out_data_o, // head word
  output logic              out_valid_o,// head valid
  input  wire logic         out_ready_i // drain
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o  = mem_r[rp_r];

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // absr_skid

// ---- design/absr_host.sv ----
// host end: drives selects, strobes and serial clock, collects words
`timescale 1ns/100ps
`include "absr_regs.svh"
module absr_host
  import absr_pkg::*;
#(
  parameter int HALF_CYC = `ABSR_HOST_HALF_CYC, // core cycles per half
  parameter int SYNC     = 4                    // cycles for pin settle
) (
  input  wire logic       core_clk_i,  // core clock
  input  wire logic       arst_n_i,    // async reset, active low
  absr_if.host            lnk,         // pins toward the device
  input  wire logic       start_i,     // pulse: read all channels
  input  wire logic       serial_i,    // 1 serial, 0 byte mode
  input  wire logic       hi_first_i,  // byte mode upper byte first
  output absr_pkg::absr_word_t word_o, // collected word (output a or byte lines)
  output logic            word_vld_o,  // pulse: word_o valid
  output logic            first_o,     // marker seen with this word
  output logic            busy_o       // frame in progress
);
  import absr_pkg::*;
  typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END} absr_hst_e;
  absr_hst_e st_r;
  logic [15:0] tmr_r;
  logic [7:0]  cnt_r;
  logic [15:0] sh_r;
  logic        mk_r;
  logic [1:0]  da_r, mk_s_r;
  logic [7:0]  db1_r, db2_r;
  logic        ser_r, ord_r, cs_r, rd_r, ck_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      da_r   <= 2'h0;
      mk_s_r <= 2'h0;
      db1_r  <= 8'h00;
      db2_r  <= 8'h00;
    end else begin
      da_r   <= {da_r[0], lnk.serial_out_a};
      mk_s_r <= {mk_s_r[0], lnk.first_channel_marker};
      db1_r  <= lnk.low_byte_lines;
      db2_r  <= db1_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r       <= H_IDLE;
      tmr_r      <= 16'h0;
      cnt_r      <= 8'h0;
      sh_r       <= 16'h0;
      mk_r       <= 1'b0;
      ser_r      <= 1'b0;
      ord_r      <= 1'b1;
      cs_r       <= 1'b1;
      rd_r       <= 1'b1;
      ck_r       <= 1'b1;
      word_o     <= 16'h0;
      word_vld_o <= 1'b0;
      first_o    <= 1'b0;
    end else begin
      word_vld_o <= 1'b0;
      if (tmr_r != 16'h0) tmr_r <= tmr_r - 16'h1;
      unique case (st_r)
        H_IDLE: if (start_i) begin
          ser_r <= serial_i;
          ord_r <= hi_first_i;
          cnt_r <= 8'h0;
          tmr_r <= 16'(HALF_CYC + SYNC);
          st_r  <= H_SETUP;
        end
        H_SETUP: if (tmr_r == 16'h0) begin
          cs_r  <= 1'b0;
          tmr_r <= 16'(HALF_CYC + SYNC);
          st_r  <= H_HIGH;
        end
        H_HIGH: if (tmr_r == 16'h0) begin
          // falling edge only; the bit/byte is captured at the end of H_LOW
          if (ser_r) begin
            ck_r <= 1'b0;
          end else begin
            rd_r <= 1'b0;
          end
          tmr_r <= 16'(HALF_CYC + SYNC);
          st_r  <= H_LOW;
        end
        H_LOW: if (tmr_r == 16'h0) begin
          cnt_r <= cnt_r + 8'h1;
          if (ser_r) begin
            sh_r <= {sh_r[14:0], da_r[1]};
            if (cnt_r[3:0] == 4'h0) mk_r <= mk_s_r[1];
            if (cnt_r[3:0] == 4'hf) begin
              word_o     <= {sh_r[14:0], da_r[1]};
              word_vld_o <= 1'b1;
              first_o <= mk_r;
            end
            ck_r <= 1'b1;
          end else begin
            if (!cnt_r[0]) begin
              sh_r[7:0] <= db2_r;
              mk_r      <= mk_s_r[1];
            end else begin
              word_o <= ord_r ? {sh_r[7:0], db2_r} : {db2_r, sh_r[7:0]};
              word_vld_o <= 1'b1;
              first_o    <= mk_r;
            end
            rd_r <= 1'b1;
          end
          tmr_r <= 16'(HALF_CYC + SYNC);
          // 128 serial clocks or 16 read pulses per frame
          if (cnt_r == (ser_r ? 8'(`ABSR_SER_TOTAL - 1)
                              : 8'(`ABSR_BYTE_READS - 1))) begin
            st_r <= H_END;
          end else begin
            st_r <= H_HIGH;
          end
        end
        H_END: if (tmr_r == 16'h0) begin
          cs_r <= 1'b1;
          st_r <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign lnk.interface_select   = 1'b1;
  assign lnk.byte_serial_select = ~ser_r;
  assign lnk.byte_order_select  = ord_r;
  assign lnk.cs_n               = cs_r;
  assign lnk.rd_n               = rd_r;
  assign lnk.sclk               = ck_r;
  assign busy_o                 = (st_r != H_IDLE);
endmodule // absr_host

// ---- tb/absr_props.sv ----
// assertions on the pins between the converter end and the host end
`timescale 1ns/100ps
module absr_props (
  input wire logic       core_clk_i,           // core clock
  input wire logic       arst_n_i,             // async reset, active low
  input wire logic       interface_select,     // high: byte or serial
  input wire logic       byte_serial_select,   // high byte, low serial
  input wire logic       cs_n,                 // chip select
  input wire logic       rd_n,                 // read strobe
  input wire logic       sclk,                 // serial clock
  input wire logic [7:0] low_byte_lines,       // byte data
  input wire logic       low_byte_oe,          // byte data driven
  input wire logic       serial_out_a,         // serial data a
  input wire logic       serial_oe,            // serial outputs driven
  input wire logic       first_channel_marker, // marker
  input wire logic       marker_oe             // marker driven
);
  logic [7:0] ev_cnt_r;
  logic       sclk_q_r;
  logic       rd_q_r;
  logic       ser;
  logic       byt;
  assign ser = interface_select && !byte_serial_select;
  assign byt = interface_select && byte_serial_select;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========
  // strobe edges since chip select fell; saturates so a stuck host
  // cannot wrap it back into the marker window
  // previous strobe levels reset to their idle high, so no false edge
  // is counted just after reset
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_q_r <= 1'b1;
      rd_q_r   <= 1'b1;
    end else begin
      sclk_q_r <= sclk;
      rd_q_r   <= rd_n;
    end
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ev_cnt_r <= 8'h00;
    end else if (cs_n) begin
      ev_cnt_r <= 8'h00;
    end else if (((sclk_q_r && !sclk) || (!rd_q_r && rd_n)) &&
                 ev_cnt_r != 8'hff) begin
      ev_cnt_r <= ev_cnt_r + 8'h01;
    end
  end
  // ==========
  // checks
  a_float_cs_high: assert property (
    cs_n [*6] |-> !serial_oe && !low_byte_oe && !marker_oe)
    else $error("outputs driven while chip select high");
  a_ser_frame_start: assert property (
    $fell(cs_n) && ser |-> ##[1:8] serial_oe && marker_oe &&
    first_channel_marker)
    else $error("serial frame did not start");
  a_byte_bus_on: assert property (
    $fell(cs_n) && byt |-> ##[1:8] low_byte_oe)
    else $error("byte lines not enabled");
  a_byte_no_serial: assert property (
    (!cs_n && byt) [*8] |-> !serial_oe)
    else $error("serial outputs driven in byte mode");
  a_ser_no_byte: assert property (
    (!cs_n && ser) [*8] |-> !low_byte_oe)
    else $error("byte lines driven in serial mode");
  a_ser_bit_hold: assert property (
    $fell(sclk) && serial_oe |=> $stable(serial_out_a) [*6])
    else $error("serial bit moved on falling clock");
  a_byte_hold: assert property (
    $rose(rd_n) && low_byte_oe |=> ($stable(low_byte_lines) || cs_n) [*4])
    else $error("byte moved on rising read strobe");
  a_ser_marker_hi: assert property (
    ser && !cs_n && ev_cnt_r inside {[8'd1:8'd15]} |-> first_channel_marker)
    else $error("marker low within first word");
  a_ser_marker_lo: assert property (
    ser && !cs_n && ev_cnt_r >= 8'd17 |-> serial_oe && !first_channel_marker)
    else $error("marker high or outputs off after first word");
  a_byte_marker: assert property (
    $rose(rd_n) && byt && !cs_n |->
    marker_oe && first_channel_marker == (ev_cnt_r < 8'd2))
    else $error("byte marker wrong for this read");
endmodule // absr_props

// ---- tb/testbench.sv ----
// self-checking bench: host end and converter end joined by the pins
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin \
  error_cnt++; $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module testbench;
  import absr_pkg::*;
  logic         core_clk_i = 1'b0;
  logic         arst_n_i   = 1'b0;
  logic         start      = 1'b0;
  logic         serial     = 1'b0;
  logic         hi_first   = 1'b1;
  logic         busy       = 1'b0;
  logic [127:0] result     = 128'h0;
  absr_word_t   word;
  logic         word_vld;
  logic         first;
  logic         h_busy;
  absr_mode_e   mode;
  int           error_cnt  = 0;
  int           n_tests    = 0;
  int           w_idx      = 0;
  int           e_idx      = 0;
  absr_word_t   lat [8];
  absr_if lnk_if ();
  absr_dev absr_dev_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .lnk(lnk_if.dev), .busy_i(busy), .result_i(result), .mode_o(mode));
  absr_host absr_host_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .lnk(lnk_if.host), .start_i(start), .serial_i(serial),
    .hi_first_i(hi_first), .word_o(word), .word_vld_o(word_vld),
    .first_o(first), .busy_o(h_busy));
  absr_props absr_props_inst (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .interface_select(lnk_if.interface_select),
    .byte_serial_select(lnk_if.byte_serial_select), .cs_n(lnk_if.cs_n),
    .rd_n(lnk_if.rd_n), .sclk(lnk_if.sclk),
    .low_byte_lines(lnk_if.low_byte_lines),
    .low_byte_oe(lnk_if.low_byte_oe), .serial_out_a(lnk_if.serial_out_a),
    .serial_oe(lnk_if.serial_oe),
    .first_channel_marker(lnk_if.first_channel_marker),
    .marker_oe(lnk_if.marker_oe));
  always #2.5 core_clk_i = ~core_clk_i;
  // ==========
  // model of the result stream
  function automatic absr_byte_t exp_byte(int k);
    absr_word_t w;
    w = lat[k / 2];
    return ((k % 2 == 0) == hi_first) ? w[15:8] : w[7:0];
  endfunction
  function automatic logic exp_bit_b(int n);
    absr_word_t w;
    w = lat[(n / 16 + 4) % 8];
    return w[15 - n % 16];
  endfunction
  always @(posedge core_clk_i) begin
    if (word_vld === 1'b1) begin
      `CHK("word", lat[w_idx % 8], word)
      `CHK("first", w_idx == 0, first)
      w_idx++;
    end
  end
  always @(negedge lnk_if.cs_n) e_idx = 0;
  // sampled at the rising strobe, when the host also takes the value
  always @(posedge lnk_if.rd_n) begin
    if (lnk_if.cs_n === 1'b0) begin
      `CHK("byte", exp_byte(e_idx), lnk_if.low_byte_lines)
      e_idx++;
    end
  end
  always @(posedge lnk_if.sclk) begin
    if (lnk_if.cs_n === 1'b0) begin
      `CHK("bit_b", exp_bit_b(e_idx), lnk_if.serial_out_b)
      e_idx++;
    end
  end
  // ==========
  // tasks
  task automatic tick(int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic convert();
    busy = 1'b1;
    for (int c = 0; c < 8; c++) result[c*16 +: 16] = 16'($urandom);
    tick(4);
  endtask
  task automatic conv_done();
    busy = 1'b0;
    for (int c = 0; c < 8; c++) lat[c] = result[c*16 +: 16];
    tick(6);
  endtask
  task automatic read_all(logic ser, logic hf);
    int t;
    serial = ser;
    hi_first = hf;
    w_idx = 0;
    tick(10);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    t = 0;
    while (h_busy === 1'b1 && t < 6000) begin
      tick(1);
      t++;
    end
    tick(20);
    `CHK("words", 8, w_idx)
    `CHK("edges", ser ? 128 : 16, e_idx)
    `CHK("mode", ser ? ABSR_MODE_SER : ABSR_MODE_BYTE, mode)
    $display("test done: serial %0d hi_first %0d", ser, hf);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    void'($urandom(3374));
    tick(10);
    arst_n_i = 1'b1;
    tick(1);
    convert();
    conv_done();
    read_all(1'b0, 1'b1);
    read_all(1'b0, 1'b0);
    read_all(1'b1, 1'b0);
    // next conversion running: reads must still see the older set
    convert();
    read_all(1'b1, 1'b0);
    read_all(1'b0, 1'b1);
    conv_done();
    repeat (3) begin
      convert();
      conv_done();
      read_all(1'($urandom), 1'($urandom));
    end
    print_verdict();
  end
  // generous bound: 60,000 cycles for eight frames of at most about 2,600 cycles each
  initial begin
    #(60000 * 5);
    error_cnt++;
    print_verdict();
  end
endmodule // testbench
